// [still_warn_pkg.sv]
// Constants shared by the stillness timer and motion warning block.
// Assumes an 8-bit register port with byte addresses as printed.
package still_warn_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_Z_STILL_HIGH = 8'h2E;
  localparam logic [7:0] ADDR_Z_STILL_LOW  = 8'h2F;
  localparam logic [7:0] ADDR_DUR_HIGH     = 8'h30;
  localparam logic [7:0] ADDR_DUR_LOW      = 8'h31;
  localparam logic [7:0] ADDR_X_WARN_HIGH  = 8'h32;
  localparam logic [7:0] ADDR_X_WARN_LOW   = 8'h33;
  localparam logic [7:0] ADDR_Y_WARN_HIGH  = 8'h34;
  localparam logic [7:0] ADDR_Y_WARN_LOW   = 8'h35;

  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions in the low threshold registers
  localparam int THR_LSB_HI    = 7;
  localparam int THR_LSB_LO    = 5;
  localparam int REF_SEL_BIT   = 1;
  localparam int AXIS_EN_BIT   = 0;

  // Writable masks of the low registers; reserved bits stay zero
  localparam logic [7:0] MASK_LOW_REF = 8'hE3;
  localparam logic [7:0] MASK_LOW     = 8'hE1;

  // Duration step in microseconds and the code scaling
  localparam int STEP_SLOW_US = 32500;
  localparam int STEP_FAST_US = 16250;
  localparam int RATE_FAST_HZ = 5120;
  localparam int RATE_SLOW_HZ = 2560;

  // Samples per duration code: 32.5 ms x 2560 Hz, 16.25 ms x 5120 Hz
  localparam int SAMPLES_SLOW = STEP_SLOW_US * RATE_SLOW_HZ / 1000000;
  localparam int SAMPLES_FAST = STEP_FAST_US * RATE_FAST_HZ / 1000000;

  // Rate select codes
  localparam logic [2:0] RATE_CODE_5120 = 3'h4;

endpackage

// [axis_magnitude_cmp.sv]
// Compares the magnitude of one signed 12-bit sample with an 11-bit
// threshold. Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module axis_magnitude_cmp (
  // Sample and reference
  input  wire logic signed [11:0] sample,
  input  wire logic signed [11:0] reference,
  input  wire logic               use_reference,
  // Threshold and result
  input  wire logic [10:0]        threshold,
  output logic                    at_or_above
);

  logic signed [12:0] diff;
  logic        [12:0] magnitude;

  // Difference widened by one bit so that -2048 minus 2047 fits
  assign diff      = use_reference ? (13'(sample) - 13'(reference))
                                   : 13'(sample);
  assign magnitude = diff[12] ? 13'(-diff) : 13'(diff);
  assign at_or_above = magnitude >= {2'h0, threshold};

endmodule
`default_nettype wire

// [still_warn_detect.sv]
// Stillness timer and motion warning detector of the accelerometer.
// Assumes an 8-bit register port, one sample strobe per output sample
// and a rate code from the timing logic outside.
//
// How it works
// - Z stillness threshold bits 10:3 come from the z high register.
// - Z threshold bits 2:0 from low register bits 7:5; 4:1 read zero.
// - Z low register bit 0 enables z-axis in stillness detection.
// - Stillness event only after enabled axes stay low for the duration.
// - Duration is high register bits 15:8 and low register bits 7:0.
// - Duration step 32.5 ms up to 2560 Hz, 16.25 ms at 5120 Hz.
// - Warning thresholds are 11-bit unsigned codes at 100 mg each.
// - Warning compares each enabled axis magnitude to its threshold.
// - X warning threshold from x high bits 10:3 and x low 7:5.
// - Y warning threshold from y high bits 10:3 and y low 7:5.
// - X low bit 1 picks referenced (1) or absolute (0) warning.
// - X low bit 0 enables x-axis in warning detection.
// - Y low bit 0 enables y-axis in warning detection.
// - All eight registers hold zero after reset.
// - Stillness compares each enabled axis magnitude to its threshold.
// - Stillness reference select picks referenced or absolute mode.
// - Z warning enable bit includes z-axis in warning detection.
`timescale 1ns/1ps
`default_nettype none
module still_warn_detect
  import still_warn_pkg::*;
(
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Register port
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  output logic                    reg_hit,
  // Acceleration samples, one strobe per output sample
  input  wire logic               sample_valid,
  input  wire logic signed [11:0] x_sample,
  input  wire logic signed [11:0] y_sample,
  input  wire logic signed [11:0] z_sample,
  input  wire logic [2:0]         output_sample_rate,
  // Settings held outside this block
  input  wire logic [10:0]        x_still_threshold,
  input  wire logic [10:0]        y_still_threshold,
  input  wire logic               x_still_axis_enable,
  input  wire logic               y_still_axis_enable,
  input  wire logic               still_reference_select,
  input  wire logic [10:0]        z_warn_threshold,
  input  wire logic               z_warn_axis_enable,
  // Events to the interrupt mapping
  output logic                    still_event,
  output logic                    warn_event,
  output logic [15:0]             still_duration_code
);

  // Register storage
  logic [7:0] z_still_high_reg, z_still_low_reg;
  logic [7:0] dur_high_reg, dur_low_reg;
  logic [7:0] x_warn_high_reg, x_warn_low_reg;
  logic [7:0] y_warn_high_reg, y_warn_low_reg;

  // Write strobes per address
  logic wr_z_hi, wr_z_lo, wr_d_hi, wr_d_lo;
  logic wr_x_hi, wr_x_lo, wr_y_hi, wr_y_lo;
  assign wr_z_hi = reg_write && reg_addr == ADDR_Z_STILL_HIGH;
  assign wr_z_lo = reg_write && reg_addr == ADDR_Z_STILL_LOW;
  assign wr_d_hi = reg_write && reg_addr == ADDR_DUR_HIGH;
  assign wr_d_lo = reg_write && reg_addr == ADDR_DUR_LOW;
  assign wr_x_hi = reg_write && reg_addr == ADDR_X_WARN_HIGH;
  assign wr_x_lo = reg_write && reg_addr == ADDR_X_WARN_LOW;
  assign wr_y_hi = reg_write && reg_addr == ADDR_Y_WARN_HIGH;
  assign wr_y_lo = reg_write && reg_addr == ADDR_Y_WARN_LOW;

  // Register writes; reserved bits masked so they never store
  always_ff @(posedge clock) begin
    if (rst) begin
      z_still_high_reg <= REG_RESET;
      z_still_low_reg  <= REG_RESET;
      dur_high_reg     <= REG_RESET;
      dur_low_reg      <= REG_RESET;
      x_warn_high_reg  <= REG_RESET;
      x_warn_low_reg   <= REG_RESET;
      y_warn_high_reg  <= REG_RESET;
      y_warn_low_reg   <= REG_RESET;
    end else begin
      if (wr_z_hi) z_still_high_reg <= reg_wdata;
      if (wr_z_lo) z_still_low_reg  <= reg_wdata & MASK_LOW;
      if (wr_d_hi) dur_high_reg     <= reg_wdata;
      if (wr_d_lo) dur_low_reg      <= reg_wdata;
      if (wr_x_hi) x_warn_high_reg  <= reg_wdata;
      if (wr_x_lo) x_warn_low_reg   <= reg_wdata & MASK_LOW_REF;
      if (wr_y_hi) y_warn_high_reg  <= reg_wdata;
      if (wr_y_lo) y_warn_low_reg   <= reg_wdata & MASK_LOW;
    end
  end

  // Read select; unmapped addresses answer zero with no hit
  logic [7:0] rd_mux;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (reg_addr)
      ADDR_Z_STILL_HIGH: rd_mux = z_still_high_reg;
      ADDR_Z_STILL_LOW:  rd_mux = z_still_low_reg;
      ADDR_DUR_HIGH:     rd_mux = dur_high_reg;
      ADDR_DUR_LOW:      rd_mux = dur_low_reg;
      ADDR_X_WARN_HIGH:  rd_mux = x_warn_high_reg;
      ADDR_X_WARN_LOW:   rd_mux = x_warn_low_reg;
      ADDR_Y_WARN_HIGH:  rd_mux = y_warn_high_reg;
      ADDR_Y_WARN_LOW:   rd_mux = y_warn_low_reg;
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end else if (reg_read) begin
      reg_rdata <= rd_mux;
      reg_hit   <= rd_hit;
    end else begin
      reg_hit   <= 1'b0;
    end
  end

  // Assembled fields
  logic [10:0] z_still_threshold, x_warn_threshold, y_warn_threshold;
  logic        z_still_axis_enable, x_warn_axis_enable, y_warn_axis_enable;
  logic        warn_reference_select;
  logic [15:0] still_duration;
  assign z_still_threshold = {z_still_high_reg,
                    z_still_low_reg[THR_LSB_HI:THR_LSB_LO]};
  assign x_warn_threshold  = {x_warn_high_reg,
                    x_warn_low_reg[THR_LSB_HI:THR_LSB_LO]};
  assign y_warn_threshold  = {y_warn_high_reg,
                    y_warn_low_reg[THR_LSB_HI:THR_LSB_LO]};
  assign z_still_axis_enable   = z_still_low_reg[AXIS_EN_BIT];
  assign x_warn_axis_enable    = x_warn_low_reg[AXIS_EN_BIT];
  assign y_warn_axis_enable    = y_warn_low_reg[AXIS_EN_BIT];
  assign warn_reference_select = x_warn_low_reg[REF_SEL_BIT];
  assign still_duration = {dur_high_reg, dur_low_reg};

  // References: captured sample at the moment the first of the two modes arms.
  // Kept simple: a reference is the last sample seen while disarmed.
  logic signed [11:0] ref_reg [3];
  logic               armed_reg;
  logic               armed_next;
  assign armed_next = still_reference_select | warn_reference_select;
  always_ff @(posedge clock) begin
    if (rst) begin
      armed_reg  <= 1'b0;
      ref_reg[0] <= 12'sh000;
      ref_reg[1] <= 12'sh000;
      ref_reg[2] <= 12'sh000;
    end else begin
      armed_reg <= armed_next;
      if (sample_valid && !armed_reg) begin
        ref_reg[0] <= x_sample;
        ref_reg[1] <= y_sample;
        ref_reg[2] <= z_sample;
      end
    end
  end

  // Per-axis comparisons, stillness then warning
  logic signed [11:0] samp   [3];
  logic [10:0]        s_thr  [3];
  logic [10:0]        w_thr  [3];
  logic [2:0]         s_en, w_en, s_over, w_over;
  assign samp[0] = x_sample;
  assign samp[1] = y_sample;
  assign samp[2] = z_sample;
  assign s_thr[0] = x_still_threshold;
  assign s_thr[1] = y_still_threshold;
  assign s_thr[2] = z_still_threshold;
  assign w_thr[0] = x_warn_threshold;
  assign w_thr[1] = y_warn_threshold;
  assign w_thr[2] = z_warn_threshold;
  assign s_en = {z_still_axis_enable, y_still_axis_enable,
                 x_still_axis_enable};
  assign w_en = {z_warn_axis_enable, y_warn_axis_enable,
                 x_warn_axis_enable};

  genvar a;
  generate
    for (a = 0; a < 3; a++) begin : g_axis
      axis_magnitude_cmp u_still (
        .sample        (samp[a]),
        .reference     (ref_reg[a]),
        .use_reference (still_reference_select),
        .threshold     (s_thr[a]),
        .at_or_above   (s_over[a])
      );
      axis_magnitude_cmp u_warn (
        .sample        (samp[a]),
        .reference     (ref_reg[a]),
        .use_reference (warn_reference_select),
        .threshold     (w_thr[a]),
        .at_or_above   (w_over[a])
      );
    end
  endgenerate

  // Any enabled axis over threshold
  logic still_broken, warn_hit, any_still_en;
  assign still_broken = |(s_over & s_en);
  assign warn_hit     = |(w_over & w_en);
  assign any_still_en = |s_en;

  // Samples per duration code depend on the rate
  logic [6:0] samples_per_code;
  assign samples_per_code = (output_sample_rate == RATE_CODE_5120)
                            ? 7'(SAMPLES_FAST - 1)
                            : 7'(SAMPLES_SLOW - 1);

  // Stillness duration timer; only on sample strobes
  logic [6:0]  sub_reg;
  logic [15:0] code_reg;
  logic        fired_reg;
  logic        code_done;
  assign code_done = sub_reg >= samples_per_code;
  always_ff @(posedge clock) begin
    if (rst) begin
      sub_reg   <= 7'h00;
      code_reg  <= 16'h0000;
      fired_reg <= 1'b0;
    end else if (sample_valid) begin
      if (still_broken || !any_still_en) begin
        sub_reg   <= 7'h00;
        code_reg  <= 16'h0000;
        fired_reg <= 1'b0;
      end else if (!fired_reg && code_reg >= still_duration) begin
        fired_reg <= 1'b1;
      end else if (!fired_reg) begin
        sub_reg  <= code_done ? 7'h00 : sub_reg + 7'h01;
        code_reg <= code_done ? code_reg + 16'h0001 : code_reg;
      end
    end
  end

  // Event pulses, one clock long, each from a flip-flop
  always_ff @(posedge clock) begin
    if (rst) begin
      still_event         <= 1'b0;
      warn_event          <= 1'b0;
      still_duration_code <= 16'h0000;
    end else begin
      still_event <= sample_valid && !still_broken && any_still_en &&
                     !fired_reg && code_reg >= still_duration;
      warn_event  <= sample_valid && warn_hit;
      still_duration_code <= code_reg;
    end
  end

endmodule
`default_nettype wire

// [still_warn_assertions.sv]
// Port checker for the stillness and warning detector.
// Assumes it is bound to every still_warn_detect instance.
`timescale 1ns/1ps
`default_nettype none
module still_warn_assertions
  import still_warn_pkg::*;
(
  // Clock, reset and register answer
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               reg_read,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_hit,
  // Samples and outside settings
  input wire logic               sample_valid,
  input wire logic signed [11:0] x_sample,
  input wire logic [10:0]        x_still_threshold,
  input wire logic               x_still_axis_enable,
  input wire logic               still_reference_select,
  // Events
  input wire logic               still_event,
  input wire logic               warn_event
);
  // Decodes; absolute mode only, the reference is not visible here
  wire logic        mapped = reg_addr >= 8'h2E && reg_addr <= 8'h35;
  wire logic [11:0] x_mag  = x_sample[11] ? -x_sample : x_sample;
  wire logic        x_loud = x_still_axis_enable && !still_reference_select
                             && x_mag >= {1'b0, x_still_threshold};

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_reset_quiet: assert property (
    $fell(rst) |-> !still_event && !warn_event)
    else $error("event seen right after reset");
  a_unmapped_read: assert property (
    reg_read && !mapped |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read answered");
  a_xlow_reserved: assert property (
    reg_read && reg_addr == ADDR_X_WARN_LOW
    |=> reg_hit && (reg_rdata & ~MASK_LOW_REF) == 8'h00)
    else $error("x low reserved bits set");
  a_low_reserved: assert property (
    reg_read && (reg_addr == ADDR_Z_STILL_LOW || reg_addr == ADDR_Y_WARN_LOW)
    |=> reg_hit && (reg_rdata & ~MASK_LOW) == 8'h00)
    else $error("low reserved bits set");
  a_warn_on_sample: assert property (
    warn_event |-> $past(sample_valid))
    else $error("warning without a sample");
  a_still_on_sample: assert property (
    still_event |-> $past(sample_valid))
    else $error("stillness without a sample");
  a_still_single: assert property (
    still_event |=> !still_event)
    else $error("stillness event longer than one cycle");
  a_loud_restarts: assert property (
    sample_valid && x_loud |=> !still_event)
    else $error("stillness despite loud sample");
endmodule

bind still_warn_detect still_warn_assertions i_still_warn_assertions (
  .clock(clock), .rst(rst), .reg_read(reg_read), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit), .sample_valid(sample_valid),
  .x_sample(x_sample), .x_still_threshold(x_still_threshold),
  .x_still_axis_enable(x_still_axis_enable),
  .still_reference_select(still_reference_select),
  .still_event(still_event), .warn_event(warn_event));
`default_nettype wire

// [host_reg_model.sv]
// Host model that drives the byte register port on falling edges.
// Assumes the bench calls its tasks; strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none
module host_reg_model (
  // Clock and answer
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit,
  // Requests
  output var logic        reg_write = 1'b0,
  output var logic        reg_read  = 1'b0,
  output var logic [7:0]  reg_addr  = 8'h00,
  output var logic [7:0]  reg_wdata = 8'h00
);
  // Released lines show inverted values so stale data cannot pass
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge clock);
    {reg_write, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask

  // Answer is taken in the cycle after the read edge
  task automatic read(input logic [7:0] a, output logic [7:0] d,
                      output logic h);
    @(negedge clock);
    {reg_read, reg_addr} = {1'b1, a};
    @(negedge clock);
    {reg_read, reg_addr} = {1'b0, ~a};
    d = reg_rdata;
    h = reg_hit;
  endtask
endmodule
`default_nettype wire

// [tb_still_warn_detect.sv]
// Bench for the stillness timer and motion warning detector.
// Assumes host_reg_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_still_warn_detect
  import still_warn_pkg::*;
;
  logic               clock = 1'b0;
  logic               rst   = 1'b1;
  logic               sample_valid = 1'b0;
  logic signed [11:0] xs = 12'h000, ys = 12'h000, zs = 12'h000;
  logic [2:0]         rate  = 3'h3;
  logic [10:0]        z_thr = 11'h000;
  logic               z_en  = 1'b0;
  logic               sref  = 1'b0;
  wire logic [7:0]    reg_rdata, reg_addr, reg_wdata;
  wire logic          reg_hit, reg_write, reg_read, still_event, warn_event;
  wire logic [15:0]   code;
  int                 n_errors = 0, total_checks = 0;

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // Y stillness stays fixed; the stillness reference select is driven
  still_warn_detect i_still_warn_detect (
    .clock(clock), .rst(rst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .sample_valid(sample_valid), .x_sample(xs),
    .y_sample(ys), .z_sample(zs), .output_sample_rate(rate),
    .x_still_threshold(11'h064), .y_still_threshold(11'h064),
    .x_still_axis_enable(1'b1), .y_still_axis_enable(1'b0),
    .still_reference_select(sref), .z_warn_threshold(z_thr),
    .z_warn_axis_enable(z_en), .still_event(still_event),
    .warn_event(warn_event), .still_duration_code(code));
  host_reg_model i_host_reg_model (
    .clock(clock), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_reg_model.write(a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    logic [7:0] d;
    logic       g;
    i_host_reg_model.read(a, d, g);
    chk(d, e);
    chk(g, h);
  endtask

  // One sample strobe; events are looked at in the following cycle
  task automatic samp(input logic signed [11:0] x, y, z, output logic w, s);
    @(negedge clock);
    {sample_valid, xs, ys, zs} = {1'b1, x, y, z};
    @(negedge clock);
    {sample_valid, xs, ys, zs} = {1'b0, ~x, ~y, ~z};
    w = warn_event;
    s = still_event;
  endtask

  task automatic wcase(input logic signed [11:0] x, y, z, input logic e);
    logic w, s;
    samp(x, y, z, w, s);
    chk(w, e);
  endtask

  // Quiet samples until a stillness event, bounded by lim
  task automatic quiet(input logic signed [11:0] z, input int lim,
                       output int cnt);
    logic w, s;
    cnt = 0;
    s = 1'b0;
    while (s !== 1'b1 && cnt < lim) begin
      samp(12'h000, 12'h000, z, w, s);
      cnt++;
    end
  endtask

  initial begin
    logic [7:0] a;
    logic       w, s;
    int         cnt;
    repeat (2) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(ADDR_Z_STILL_HIGH + 8'(i), 8'h00, 1'b1);
    // Full write, read back through the writable masks
    for (int i = 0; i < 8; i++) begin
      a = ADDR_Z_STILL_HIGH + 8'(i);
      wr(a, 8'hFF);
      rd(a, a == ADDR_X_WARN_LOW ? MASK_LOW_REF : (a == ADDR_Z_STILL_LOW || a == ADDR_Y_WARN_LOW) ? MASK_LOW : 8'hFF, 1'b1);
    end
    wr(8'h36, 8'hFF);
    rd(8'h36, 8'h00, 1'b0);
    rd(8'h2D, 8'h00, 1'b0);
    // Warning thresholds: x 133, y 11
    wr(ADDR_X_WARN_HIGH, 8'h10);
    wr(ADDR_X_WARN_LOW, 8'hA1);
    wr(ADDR_Y_WARN_HIGH, 8'h01);
    wr(ADDR_Y_WARN_LOW, 8'h61);
    wcase(12'sd133, 12'sd0, 12'sd0, 1'b1);
    wcase(-12'sd133, 12'sd0, 12'sd0, 1'b1);
    wcase(12'sd132, 12'sd0, 12'sd0, 1'b0);
    wcase(12'sd0, 12'sd11, 12'sd0, 1'b1);
    wcase(12'sd0, -12'sd10, 12'sd0, 1'b0);
    {z_thr, z_en} = {11'h014, 1'b1};
    wcase(12'sd0, 12'sd0, -12'sd20, 1'b1);
    z_en = 1'b0;
    wcase(12'sd0, 12'sd0, -12'sd20, 1'b0);
    // Reference frozen at 300, then referenced and masked x
    wcase(12'sd300, 12'sd0, 12'sd0, 1'b1);
    wr(ADDR_X_WARN_LOW, 8'hA3);
    wcase(12'sd300, 12'sd0, 12'sd0, 1'b0);
    wr(ADDR_X_WARN_LOW, 8'hA0);
    wcase(12'sd300, 12'sd0, 12'sd0, 1'b0);
    // Stillness: z threshold 17, duration 2 codes of 83 samples
    wr(ADDR_Z_STILL_HIGH, 8'h02);
    wr(ADDR_Z_STILL_LOW, 8'h20);
    wr(ADDR_DUR_HIGH, 8'h00);
    wr(ADDR_DUR_LOW, 8'h02);
    for (int r = 3; r < 5; r++) begin
      rate = 3'(r);
      samp(12'sd200, 12'sd0, 12'sd0, w, s);
      quiet(12'sd500, 400, cnt);
      chk(16'(cnt >= 166 && cnt <= 167), 16'h0001);
    end
    wr(ADDR_Z_STILL_LOW, 8'h21);
    samp(12'sd200, 12'sd0, 12'sd0, w, s);
    quiet(12'sd16, 100, cnt);
    chk(16'(cnt), 16'd100);
    samp(12'sd0, 12'sd0, 12'sd17, w, s);
    quiet(12'sd16, 400, cnt);
    chk(16'(cnt >= 166 && cnt <= 167), 16'h0001);
    // High duration byte: 256 codes, no event after 300 samples
    wr(ADDR_DUR_HIGH, 8'h01);
    wr(ADDR_DUR_LOW, 8'h00);
    samp(12'sd200, 12'sd0, 12'sd0, w, s);
    quiet(12'sd0, 300, cnt);
    chk(16'(cnt), 16'd300);
    chk(code, 16'h0003);
    // Zero duration: referenced stillness ignores a steady large x
    wr(ADDR_DUR_HIGH, 8'h00);
    wr(ADDR_DUR_LOW, 8'h00);
    samp(12'sd500, 12'sd0, 12'sd0, w, s);
    sref = 1'b1;
    samp(12'sd500, 12'sd0, 12'sd0, w, s);
    chk(16'(s), 16'h0001);
    sref = 1'b0;
    samp(12'sd500, 12'sd0, 12'sd0, w, s);
    chk(16'(s), 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
